// ===== src/dsa_channel.sv
`timescale 1ns/10ps
module dsa_channel import dsa_pkg::*; (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [DSA_ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic IO_REQ_I,
	output logic IO_ACK_O,
	output logic MEM_REQ_O,
	output logic MEM_WR_O,
	output logic [31:0] MEM_ADDR_O,
	output logic [63:0] MEM_WDATA_O,
	input wire logic MEM_RDY_I,
	output logic IRQ_O
);
	// ==========================================================
	// Register bus decode
	wire acc = PSEL_I && PENABLE_I;
	wire setup = PSEL_I && !PENABLE_I;
	wire wr = acc && PWRITE_I;
	wire sel_ctrl = (PADDR_I == OFS_CTRL);
	wire sel_src = (PADDR_I == OFS_SRC_ADDR);
	wire sel_inc = (PADDR_I == OFS_SRC_INC);
	wire sel_dst = (PADDR_I == OFS_DST_ADDR);
	wire sel_dinc = (PADDR_I == OFS_DST_INC);
	wire sel_cnt = (PADDR_I == OFS_COUNT);
	wire sel_flo = (PADDR_I == OFS_FILL_LO);
	wire sel_fhi = (PADDR_I == OFS_FILL_HI);
	wire sel_stat = (PADDR_I == OFS_STATUS);
	wire sel_ien = (PADDR_I == OFS_INT_EN);
	wire sel_iclr = (PADDR_I == OFS_INT_CLR);
	wire mapped = sel_ctrl || sel_src || sel_inc || sel_dst || sel_dinc || sel_cnt
		|| sel_flo || sel_fhi || sel_stat || sel_ien || sel_iclr;

	// ==========================================================
	// Registers
	dsa_state_e state_ff;
	dsa_state_e nxt_state;
	logic [7:0] ctrl_ff;
	logic [31:0] src_ff;
	logic [31:0] inc_ff;
	logic [31:0] dst_ff;
	logic [31:0] dinc_ff;
	logic [31:0] cnt_ff;
	logic [63:0] fill_ff;
	logic [EVT_W-1:0] evt_ff;
	logic [EVT_W-1:0] ien_ff;
	logic [31:0] rdata_ff;
	logic req_ff;
	logic wr_ff;
	logic ack_ff;
	logic [31:0] maddr_ff;
	logic [63:0] mwdata_ff;
	logic [2:0] ioreq_sync_ff;
	logic ioreq_ff;

	wire busy = (state_ff != DSA_IDLE);
	// Settings other than the interrupt enables are frozen while a transfer runs so the checked values stay valid
	wire cfg_wr = wr && !busy;
	wire start = cfg_wr && sel_ctrl && PWDATA_I[CTRL_START];
	wire sng = ctrl_ff[CTRL_SNG];
	wire dir = ctrl_ff[CTRL_DIR];
	wire ext = ctrl_ff[CTRL_EXT];
	wire [2:0] size = ctrl_ff[CTRL_SIZE_MSB:CTRL_SIZE_LSB];
	wire fill_mode = sng && !ext && !dir;
	wire chk_err;
	wire [31:0] walk_addr;
	wire walk_last;
	wire beat_done = (state_ff == DSA_WAIT) && MEM_RDY_I;
	wire ready_to_issue = !ext || ioreq_ff;
	wire chk_pass = (state_ff == DSA_CHECK) && !chk_err;
	wire chk_fail = (state_ff == DSA_CHECK) && chk_err;
	wire issue = (state_ff == DSA_ISSUE) && ready_to_issue;

	// ==========================================================
	// Restriction check and address walk
	dsa_cfg_check u_check (
		.sng_i(sng),
		.dir_i(dir),
		.burst_i(ctrl_ff[CTRL_BURST]),
		.size_i(size),
		.src_low_i(src_ff[2:0]),
		.src_inc_i(inc_ff),
		.count_i(cnt_ff),
		.cfg_err_o(chk_err)
	);

	// Only the source address feeds the walk; destination registers stay unused
	dsa_addr_walk u_walk (
		.REF_CLK_I(REF_CLK_I),
		.RST_I(RST_I),
		.load_i(chk_pass),
		.step_i(beat_done),
		.base_i(src_ff),
		.inc_i(inc_ff),
		.count_i(cnt_ff),
		.size_i(size),
		.addr_o(walk_addr),
		.last_o(walk_last)
	);

	// ==========================================================
	// Sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			DSA_IDLE: begin
				// Only single-address starts are handled here
				if (start && PWDATA_I[CTRL_SNG]) begin
					nxt_state = DSA_CHECK;
				end
			end
			DSA_CHECK: begin
				// Verdict before any bus cycle, so no partial transfer
				nxt_state = chk_err ? DSA_IDLE : DSA_ISSUE;
			end
			DSA_ISSUE: begin
				if (ready_to_issue) begin
					nxt_state = DSA_WAIT;
				end
			end
			DSA_WAIT: begin
				if (MEM_RDY_I) begin
					nxt_state = walk_last ? DSA_IDLE : DSA_ISSUE;
				end
			end
			default: nxt_state = DSA_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_ff <= DSA_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ==========================================================
	// Configuration registers; start bit is not stored
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ctrl_ff <= RST_CTRL;
			src_ff <= RST_WORD;
			inc_ff <= RST_WORD;
			dst_ff <= RST_WORD;
			dinc_ff <= RST_WORD;
			cnt_ff <= RST_WORD;
			fill_ff <= {RST_WORD, RST_WORD};
			ien_ff <= RST_EVT;
		end else begin
			if (cfg_wr && sel_ctrl) ctrl_ff <= {PWDATA_I[7:1], 1'b0};
			if (cfg_wr && sel_src) src_ff <= PWDATA_I;
			if (cfg_wr && sel_inc) inc_ff <= PWDATA_I;
			if (cfg_wr && sel_dst) dst_ff <= PWDATA_I;
			if (cfg_wr && sel_dinc) dinc_ff <= PWDATA_I;
			if (cfg_wr && sel_cnt) cnt_ff <= PWDATA_I;
			if (cfg_wr && sel_flo) fill_ff[31:0] <= PWDATA_I;
			if (cfg_wr && sel_fhi) fill_ff[63:32] <= PWDATA_I;
			if (wr && sel_ien) ien_ff <= PWDATA_I[EVT_W-1:0];
		end
	end

	// ==========================================================
	// Sticky events; a set in the clearing cycle wins
	wire [EVT_W-1:0] evt_set = {beat_done && walk_last, chk_fail};
	wire [EVT_W-1:0] evt_clr = (wr && sel_iclr) ? PWDATA_I[EVT_W-1:0] : RST_EVT;

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			evt_ff <= RST_EVT;
		end else begin
			evt_ff <= (evt_ff & ~evt_clr) | evt_set;
		end
	end

	assign IRQ_O = |(evt_ff & ien_ff);

	// ==========================================================
	// Read path: data latched in setup, presented in access
	wire [31:0] rd_mux = sel_ctrl ? {24'h0, ctrl_ff}
		: sel_src ? src_ff
		: sel_inc ? inc_ff
		: sel_dst ? dst_ff
		: sel_dinc ? dinc_ff
		: sel_cnt ? cnt_ff
		: sel_flo ? fill_ff[31:0]
		: sel_fhi ? fill_ff[63:32]
		: sel_stat ? {29'h0, busy, evt_ff}
		: sel_ien ? {30'h0, ien_ff}
		: RST_WORD;

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rdata_ff <= RST_WORD;
		end else if (setup) begin
			rdata_ff <= rd_mux;
		end
	end

	assign PRDATA_O = rdata_ff;
	assign PREADY_O = acc;
	assign PSLVERR_O = acc && !mapped;

	// ==========================================================
	// External request pin: three stages, change once the last two agree
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ioreq_sync_ff <= 3'h0;
			ioreq_ff <= 1'b0;
		end else begin
			ioreq_sync_ff <= {ioreq_sync_ff[1:0], IO_REQ_I};
			if (ioreq_sync_ff[1] == ioreq_sync_ff[2]) ioreq_ff <= ioreq_sync_ff[2];
		end
	end

	// ==========================================================
	// Memory cycle outputs, held until the memory answers
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			req_ff <= 1'b0;
			wr_ff <= 1'b0;
			ack_ff <= 1'b0;
			maddr_ff <= RST_WORD;
			mwdata_ff <= {RST_WORD, RST_WORD};
		end else if (issue) begin
			req_ff <= 1'b1;
			wr_ff <= !dir;
			ack_ff <= ext;
			maddr_ff <= walk_addr;
			// Fly-by writes take data from the I/O device; fill drives its own
			mwdata_ff <= fill_mode ? fill_ff : {RST_WORD, RST_WORD};
		end else if (beat_done) begin
			req_ff <= 1'b0;
			ack_ff <= 1'b0;
		end
	end

	assign MEM_REQ_O = req_ff;
	assign MEM_WR_O = wr_ff;
	assign MEM_ADDR_O = maddr_ff;
	assign MEM_WDATA_O = mwdata_ff;
	assign IO_ACK_O = ack_ff;

	// ==========================================================
	// Checks
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);

	wire [2:0] first_mask = inc_ff[31] ? dsa_size_mask(size) : 3'h0;

	AST_DUAL_NOT_STARTED: assert property (
		(state_ff == DSA_IDLE && start && !PWDATA_I[CTRL_SNG]) |=> state_ff == DSA_IDLE)
		else $error("dual-address start left idle");
	AST_ERR_FLAG_SET: assert property (
		chk_fail |=> evt_ff[STAT_CFG_ERR] && state_ff == DSA_IDLE)
		else $error("config error not flagged");
	AST_NO_CYCLE_AFTER_ERR: assert property (
		chk_fail |-> ##1 !MEM_REQ_O [*3])
		else $error("bus cycle after config error");
	AST_ZERO_INC_REFUSED: assert property (
		(state_ff == DSA_CHECK && inc_ff == RST_WORD && !dir) |=> evt_ff[STAT_CFG_ERR])
		else $error("zero increment accepted on memory write");
	AST_FIRST_ADDR_SOURCE: assert property (
		chk_pass ##1 (state_ff == DSA_ISSUE && ready_to_issue)
		|=> MEM_ADDR_O == (src_ff ^ {29'h0, first_mask}))
		else $error("first beat not at source address");
	AST_DIRECTION: assert property (
		$rose(MEM_REQ_O) |-> MEM_WR_O == !dir && IO_ACK_O == ext)
		else $error("memory direction wrong");
	AST_FILL_DATA: assert property (
		($rose(MEM_REQ_O) && fill_mode) |-> MEM_WDATA_O == fill_ff && MEM_WR_O)
		else $error("fill value not driven");
	AST_REQ_HELD: assert property (
		(MEM_REQ_O && !MEM_RDY_I) |=> MEM_REQ_O && $stable(MEM_ADDR_O))
		else $error("memory request dropped early");
	AST_REQ_ONLY_SINGLE: assert property (
		MEM_REQ_O |-> sng)
		else $error("memory cycle without single-address select");
	AST_REQ_CFG_LEGAL: assert property (
		$rose(MEM_REQ_O) |-> !chk_err)
		else $error("memory cycle on an illegal setting");
	AST_ZERO_INC_READ_ONLY: assert property (
		(MEM_REQ_O && inc_ff == RST_WORD) |-> dir && !MEM_WR_O)
		else $error("zero increment used for a memory write");
	AST_ACK_WITH_REQ: assert property (
		IO_ACK_O |-> MEM_REQ_O && ext)
		else $error("acknowledge without a memory cycle");
	AST_IDLE_NO_REQ: assert property (
		(state_ff == DSA_IDLE || state_ff == DSA_CHECK) |-> !MEM_REQ_O)
		else $error("memory cycle outside a checked transfer");
endmodule // dsa_channel

// ===== inc/dsa_pkg.sv
package dsa_pkg;
	// ==========================================================
	// Bus and register map
	localparam int DSA_ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SRC_ADDR = 8'h04;
	localparam logic [7:0] OFS_SRC_INC = 8'h08;
	localparam logic [7:0] OFS_DST_ADDR = 8'h0C;
	localparam logic [7:0] OFS_DST_INC = 8'h10;
	localparam logic [7:0] OFS_COUNT = 8'h14;
	localparam logic [7:0] OFS_FILL_LO = 8'h18;
	localparam logic [7:0] OFS_FILL_HI = 8'h1C;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_INT_EN = 8'h24;
	localparam logic [7:0] OFS_INT_CLR = 8'h28;

	// ==========================================================
	// Control register fields
	localparam int CTRL_START = 0;
	localparam int CTRL_SNG = 1;
	localparam int CTRL_DIR = 2;
	localparam int CTRL_EXT = 3;
	localparam int CTRL_BURST = 4;
	localparam int CTRL_SIZE_LSB = 5;
	localparam int CTRL_SIZE_MSB = 7;

	// ==========================================================
	// Status register fields; bits 1:0 are sticky events
	localparam int STAT_CFG_ERR = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_ACTIVE = 2;
	localparam int EVT_W = 2;

	// ==========================================================
	// Reset values and increment limits
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [EVT_W-1:0] RST_EVT = 2'h0;
	localparam logic [31:0] INC_POS8 = 32'h0000_0008;
	localparam logic [31:0] INC_NEG8 = 32'hFFFF_FFF8;

	typedef enum {DSA_IDLE, DSA_CHECK, DSA_ISSUE, DSA_WAIT} dsa_state_e;

	// Low address bits that must follow the transfer size
	function automatic logic [2:0] dsa_size_mask(input logic [2:0] size);
		case (size)
			3'h0: dsa_size_mask = 3'h0;
			3'h1: dsa_size_mask = 3'h1;
			3'h2: dsa_size_mask = 3'h3;
			default: dsa_size_mask = 3'h7;
		endcase
	endfunction

	function automatic logic [31:0] dsa_size_bytes(input logic [2:0] size);
		dsa_size_bytes = {29'h0, dsa_size_mask(size)} + 32'h1;
	endfunction
endpackage

// ===== src/dsa_cfg_check.sv
`timescale 1ns/10ps
module dsa_cfg_check import dsa_pkg::*; (
	input wire logic sng_i,
	input wire logic dir_i,
	input wire logic burst_i,
	input wire logic [2:0] size_i,
	input wire logic [2:0] src_low_i,
	input wire logic [31:0] src_inc_i,
	input wire logic [31:0] count_i,
	output logic cfg_err_o
);
	// ==========================================================
	// Restriction terms
	wire [2:0] mask = dsa_size_mask(size_i);
	wire inc_neg = src_inc_i[31];
	wire inc_zero = (src_inc_i == RST_WORD);
	wire burst_bad = burst_i && !(inc_zero || src_inc_i == INC_POS8 || src_inc_i == INC_NEG8);
	// Zero increment only legal when memory is read toward the device
	wire zero_bad = inc_zero && !dir_i;
	// Negative walk expects the low bits complemented
	wire align_bad = inc_neg ? ((src_low_i & mask) != mask) : ((src_low_i & mask) != 3'h0);
	wire count_bad = ((count_i[2:0] & mask) != 3'h0) || (count_i == RST_WORD);

	assign cfg_err_o = sng_i && (burst_bad || zero_bad || align_bad || count_bad);
endmodule // dsa_cfg_check

// ===== src/dsa_addr_walk.sv
`timescale 1ns/10ps
module dsa_addr_walk import dsa_pkg::*; (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic load_i,
	input wire logic step_i,
	input wire logic [31:0] base_i,
	input wire logic [31:0] inc_i,
	input wire logic [31:0] count_i,
	input wire logic [2:0] size_i,
	output logic [31:0] addr_o,
	output logic last_o
);
	// ==========================================================
	// Address and remaining byte count
	logic [31:0] addr_ff;
	logic [31:0] cnt_ff;
	wire [31:0] beat = dsa_size_bytes(size_i);
	wire [31:0] nxt_addr = load_i ? base_i : (step_i ? addr_ff + inc_i : addr_ff);
	wire [31:0] nxt_cnt = load_i ? count_i : (step_i ? cnt_ff - beat : cnt_ff);

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			addr_ff <= RST_WORD;
			cnt_ff <= RST_WORD;
		end else begin
			addr_ff <= nxt_addr;
			cnt_ff <= nxt_cnt;
		end
	end

	// Undo the complemented low bits so the bus sees the true beat address
	assign addr_o = inc_i[31] ? (addr_ff ^ {29'h0, dsa_size_mask(size_i)}) : addr_ff;
	assign last_o = (cnt_ff <= beat);
endmodule // dsa_addr_walk

// ===== tb/dsa_mem_model.sv
`timescale 1ns/10ps
// ==========================================================
// External memory and fly-by device seen from the channel
module dsa_mem_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire logic wr_i,
	input wire logic ack_i,
	input wire logic [31:0] addr_i,
	input wire logic [63:0] wdata_i,
	input wire logic [3:0] lat_i,
	output logic rdy_o
);
	logic [3:0] wait_ff;
	logic [31:0] q_addr[$];
	logic [1:0] q_flag[$];
	logic [63:0] q_data[$];

	// Ready is only raised while a request stands, so a stray pulse cannot end a beat
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_ff <= 4'h0;
			rdy_o <= 1'b0;
		end else if (req_i && rdy_o) begin
			q_addr.push_back(addr_i);
			q_flag.push_back({ack_i, wr_i});
			q_data.push_back(wdata_i);
			rdy_o <= 1'b0;
			wait_ff <= 4'h0;
		end else if (req_i && wait_ff >= lat_i) begin
			rdy_o <= 1'b1;
		end else if (req_i) begin
			wait_ff <= wait_ff + 4'h1;
		end
	end
endmodule // dsa_mem_model

// ===== tb/testbench.sv
`timescale 1ns/10ps
module testbench import dsa_pkg::*;;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ioreq = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdata, maddr;
	logic [31:0] seed = 32'h0000_8E0E;
	logic pready, pslverr, serr, ioack, mreq, mwr, mrdy, irq;
	logic [63:0] mwdata;
	logic [3:0] lat = 4'h0;
	int err_total = 0;
	int compares = 0;

	dsa_channel dsa_channel_i (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .IO_REQ_I(ioreq), .IO_ACK_O(ioack),
		.MEM_REQ_O(mreq), .MEM_WR_O(mwr), .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwdata),
		.MEM_RDY_I(mrdy), .IRQ_O(irq));
	dsa_mem_model dsa_mem_model_i (.clk_i(clk), .rst_i(rst), .req_i(mreq), .wr_i(mwr),
		.ack_i(ioack), .addr_i(maddr), .wdata_i(mwdata), .lat_i(lat), .rdy_o(mrdy));

	always #5 clk = ~clk;

	// ==========================================================
	// Helpers
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function logic [31:0] base();
		return rnd() & 32'hFFFF_FF00;
	endfunction

	task chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	task results;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Waits on pready with no cycle count assumed; only the watchdog ends a hang
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdata = prdata;
		serr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// ==========================================================
	// One channel run against the reference
	task run(input logic sng, dir, ext, burst, input logic [2:0] size,
		input logic [31:0] src, inc, cnt);
		int bytes, m, n;
		logic err;
		logic [1:0] en, ev;
		logic [31:0] a;
		logic [63:0] fill;
		bytes = size == 3'h0 ? 1 : size == 3'h1 ? 2 : size == 3'h2 ? 4 : 8;
		m = bytes - 1;
		err = burst && inc != 32'h8 && inc != 32'h0 && inc != 32'hFFFF_FFF8;
		err = err || (inc == 32'h0 && !dir);
		err = err || ((inc[31] ? ~src : src) & m) != 0;
		err = err || cnt % bytes != 0 || cnt == 32'h0;
		fill = {rnd(), rnd()};
		a = rnd();
		en = a[1:0];
		a = rnd();
		lat <= a[3:0];
		ioreq <= ext;
		apb(1'b1, OFS_SRC_ADDR, src);
		apb(1'b1, OFS_SRC_INC, inc);
		apb(1'b1, OFS_COUNT, cnt);
		apb(1'b1, OFS_DST_ADDR, rnd());
		apb(1'b1, OFS_DST_INC, rnd());
		apb(1'b1, OFS_FILL_LO, fill[31:0]);
		apb(1'b1, OFS_FILL_HI, fill[63:32]);
		apb(1'b1, OFS_INT_EN, {30'h0, en});
		apb(1'b1, OFS_CTRL, {24'h0, size, burst, ext, dir, sng, 1'b1});
		n = 0;
		do begin
			apb(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while (rdata[1:0] == 2'h0 && n < (sng ? 200 : 10));
		ev = !sng ? 2'h0 : err ? 2'h1 : 2'h2;
		chk(rdata[2:0], {1'b0, ev});
		chk(irq, |(ev & en));
		chk(dsa_mem_model_i.q_addr.size(), (err || !sng) ? 0 : cnt / bytes);
		a = inc[31] ? src ^ m : src;
		for (int j = 0; j < dsa_mem_model_i.q_addr.size(); j++) begin
			chk(dsa_mem_model_i.q_addr[j], a);
			chk(dsa_mem_model_i.q_flag[j], {ext, !dir});
			chk(dsa_mem_model_i.q_data[j], (!dir && !ext) ? fill : 64'h0);
			a += inc;
		end
		dsa_mem_model_i.q_addr.delete();
		dsa_mem_model_i.q_flag.delete();
		dsa_mem_model_i.q_data.delete();
		apb(1'b1, OFS_INT_CLR, 32'h3);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk({irq, rdata}, 33'h0);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rdata, {24'h0, RST_CTRL});
		apb(1'b0, OFS_STATUS, 32'h0);
		chk({irq, rdata}, 33'h0);
		apb(1'b0, 8'h3C, 32'h0);
		chk({serr, rdata}, 33'h1_0000_0000);
		run(1'b1, 1'b0, 1'b0, 1'b1, 3'h3, base(), 32'h8, 32'h18);
		run(1'b1, 1'b0, 1'b0, 1'b0, 3'h3, base(), 32'h0, 32'h8);
		run(1'b1, 1'b0, 1'b1, 1'b0, 3'h2, base(), 32'h0, 32'h8);
		run(1'b1, 1'b1, 1'b0, 1'b0, 3'h2, base(), 32'h0, 32'h8);
		run(1'b1, 1'b1, 1'b0, 1'b0, 3'h2, base() | 32'h3, 32'hFFFF_FFFC, 32'hC);
		run(1'b1, 1'b1, 1'b0, 1'b0, 3'h1, base() | 32'h1, 32'hFFFF_FFFE, 32'h4);
		run(1'b1, 1'b0, 1'b1, 1'b0, 3'h5, base() | 32'h7, 32'hFFFF_FFF8, 32'h10);
		run(1'b1, 1'b1, 1'b0, 1'b1, 3'h3, base(), 32'h10, 32'h10);
		run(1'b1, 1'b1, 1'b0, 1'b1, 3'h3, base() | 32'h7, 32'hFFFF_FFF8, 32'h10);
		run(1'b1, 1'b1, 1'b0, 1'b0, 3'h3, base(), 32'hFFFF_FFF8, 32'h8);
		run(1'b1, 1'b1, 1'b1, 1'b0, 3'h2, base() | 32'h1, 32'h4, 32'h8);
		run(1'b1, 1'b1, 1'b1, 1'b0, 3'h0, base() | 32'h5, 32'h1, 32'h3);
		run(1'b1, 1'b0, 1'b0, 1'b0, 3'h2, base(), 32'h4, 32'h6);
		run(1'b0, 1'b1, 1'b0, 1'b0, 3'h2, base(), 32'h4, 32'h8);
		run(1'b1, 1'b1, 1'b0, 1'b0, 3'h2, base(), 32'h4, 32'h0);
		results;
	end

	// Whole run needs under a thousand cycles; this margin only catches a hang
	initial begin
		#200_000;
		err_total++;
		results;
	end
endmodule // testbench
